//--- rtl/cmd_channel_cfg.svh
// Offsets, field positions and reset values of the command channel block
`ifndef CMD_CHANNEL_CFG_SVH
`define CMD_CHANNEL_CFG_SVH
`define EXT_CTRL_ADDR        16'h2138
`define EXT_CTRL_RESET       16'h0000
`define EXT_BIT_FACTORY      0
`define EXT_BIT_STORE        1
`define EXT_BIT_RESTORE      2
`define EXT_BIT_EXT_ERROR    3
`define EXT_BIT_REVERSE      12
`define EXT_BIT_LOCK         13
`define EXT_BIT_NO_CHECK     15
`define EXT_WRITABLE_MASK    16'hB00F
`define STAT_BIT_CHECK       1
`define MAP_FREE             5'h1F
`endif

//--- rtl/cmd_channel_pkg.sv
// Types of the command channel block
package cmd_channel_pkg;
  typedef enum logic [0:0] {
    CH_TERMINAL = 1'b0,
    CH_FIELDBUS = 1'b1
  } channel_t;
endpackage

//--- rtl/command_channel_and_ext_control.sv
// Command channel switching, virtual input routing and extended control word
`include "cmd_channel_cfg.svh"

module command_channel_and_ext_control #(
  parameter int N_FUNC = 4,
  parameter int N_TERM = 4
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_io_profile,
  input  wire logic                      i_three_wire,
  input  wire logic                      i_switch_from_word,
  input  wire logic [3:0]                i_switch_index,
  input  wire logic [15:0]               i_fieldbus_word,
  input  wire logic [N_TERM-1:0]         i_terminal_in,
  input  wire logic                      i_map_wr,
  input  wire logic [$clog2(N_FUNC)-1:0] i_map_func,
  input  wire logic [4:0]                i_map_bit,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [15:0]               i_reg_addr,
  input  wire logic [15:0]               i_reg_wdata,
  input  wire logic                      i_motor_powered,
  input  wire logic                      i_motor_stopped,
  input  wire logic                      i_nvm_ack,
  input  wire logic                      i_check_busy,
  output logic [15:0]                    o_reg_rdata,
  output logic                           o_map_refused,
  output logic [N_FUNC-1:0]              o_func_active,
  output logic [N_TERM-1:0]              o_terminal_free,
  output logic                           o_fieldbus_active,
  output logic                           o_ignore_wire_scheme,
  output logic                           o_run,
  output logic                           o_save_req,
  output logic                           o_factory_req,
  output logic                           o_restore_req,
  output logic                           o_ext_error,
  output logic                           o_check_enable,
  output logic                           o_device_lock,
  output logic [15:0]                    o_status
);

  if (N_FUNC < 2 || N_FUNC > 16 || ((N_FUNC & (N_FUNC - 1)) != 0)
      || N_TERM < 1 || N_TERM > 4) begin : g_bad_param
    $error("Unsupported N_FUNC or N_TERM");
  end

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  cmd_channel_pkg::channel_t chan_ff;
  cmd_channel_pkg::channel_t nxt_chan;
  logic                      switch_level;
  logic                      run_src;

  always_comb begin
    if (i_switch_from_word) begin
      switch_level = i_fieldbus_word[i_switch_index];
    end else begin
      switch_level = i_terminal_in[i_switch_index[1:0] % N_TERM];
    end
    nxt_chan = switch_level ? cmd_channel_pkg::CH_FIELDBUS : cmd_channel_pkg::CH_TERMINAL;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      chan_ff <= cmd_channel_pkg::CH_TERMINAL;
    end else begin
      chan_ff <= nxt_chan;
    end
  end

  assign o_fieldbus_active = (chan_ff == cmd_channel_pkg::CH_FIELDBUS);
  assign o_ignore_wire_scheme = i_io_profile && o_fieldbus_active;

  // Run level: fieldbus bit 0 acts at once with no edge needed
  always_comb begin
    if (o_fieldbus_active) begin
      run_src = i_fieldbus_word[0];
    end else begin
      run_src = i_terminal_in[0] && !(i_three_wire && !i_io_profile);
    end
  end
  assign o_run = run_src;

  // ----------------------------------------------------------------
  // Function to virtual bit map
  // ----------------------------------------------------------------
  logic [4:0]  map_ff     [N_FUNC];
  logic [4:0]  nxt_map    [N_FUNC];
  logic [15:0] used_bits;
  logic        refused;

  always_comb begin
    used_bits = 16'h0000;
    for (int f = 0; f < N_FUNC; f++) begin
      if (map_ff[f] != `MAP_FREE) begin
        used_bits[map_ff[f][3:0]] = 1'b1;
      end
    end
    if (i_switch_from_word) begin
      used_bits[i_switch_index] = 1'b1;
    end
    refused = i_map_wr && (i_map_bit != `MAP_FREE) && used_bits[i_map_bit[3:0]]
              && (map_ff[i_map_func] != i_map_bit);
    for (int f = 0; f < N_FUNC; f++) begin
      nxt_map[f] = map_ff[f];
    end
    if (i_map_wr && !refused) begin
      nxt_map[i_map_func] = i_map_bit;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int f = 0; f < N_FUNC; f++) begin
        map_ff[f] <= `MAP_FREE;
      end
      o_map_refused <= 1'b0;
    end else begin
      map_ff        <= nxt_map;
      o_map_refused <= refused;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_term
      assign o_terminal_free[g] = !used_bits[g];
    end
    for (g = 0; g < N_FUNC; g++) begin : g_func
      logic [3:0] pos;
      assign pos = map_ff[g][3:0];
      always_comb begin
        if (map_ff[g] == `MAP_FREE) begin
          o_func_active[g] = 1'b0;
        end else if (o_fieldbus_active) begin
          o_func_active[g] = i_fieldbus_word[pos];
        end else if (pos < N_TERM) begin
          o_func_active[g] = i_terminal_in[pos[1:0] % N_TERM];
        end else begin
          o_func_active[g] = 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Extended control word
  // ----------------------------------------------------------------
  logic [15:0] ext_ff;
  logic [15:0] nxt_ext;
  logic [3:0]  req_ff;
  logic [3:0]  nxt_req;
  logic [15:0] wr_val;
  logic        ext_wr;

  // Writes only land in working storage; saving waits for the store bit
  always_comb begin
    ext_wr  = i_reg_wr && (i_reg_addr == `EXT_CTRL_ADDR);
    wr_val  = i_reg_wdata & `EXT_WRITABLE_MASK;
    nxt_ext = ext_ff;
    nxt_req = req_ff;
    if (ext_wr) begin
      nxt_ext = wr_val;
      if (wr_val[`EXT_BIT_STORE] && !ext_ff[`EXT_BIT_STORE]) begin
        nxt_req[`EXT_BIT_STORE] = 1'b1;
      end
      if (wr_val[`EXT_BIT_FACTORY] && !ext_ff[`EXT_BIT_FACTORY] && !i_motor_powered) begin
        nxt_req[`EXT_BIT_FACTORY] = 1'b1;
      end
      if (wr_val[`EXT_BIT_RESTORE] && !ext_ff[`EXT_BIT_RESTORE] && !i_motor_powered) begin
        nxt_req[`EXT_BIT_RESTORE] = 1'b1;
      end
      if (wr_val[`EXT_BIT_EXT_ERROR] && !ext_ff[`EXT_BIT_EXT_ERROR]) begin
        nxt_req[`EXT_BIT_EXT_ERROR] = 1'b1;
      end
    end
    // Accept with no write in the same cycle clears pending factory, store and restore requests and their self-clearing bits; external error stays
    if (i_nvm_ack && !ext_wr) begin
      for (int b = 0; b < 3; b++) begin
        if (req_ff[b]) begin
          nxt_req[b] = 1'b0;
          nxt_ext[b] = 1'b0;
        end
      end
    end
    if (!ext_ff[`EXT_BIT_EXT_ERROR] || !nxt_ext[`EXT_BIT_EXT_ERROR]) begin
      nxt_req[`EXT_BIT_EXT_ERROR] = nxt_req[`EXT_BIT_EXT_ERROR] && nxt_ext[`EXT_BIT_EXT_ERROR];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ext_ff <= `EXT_CTRL_RESET;
      req_ff <= 4'h0;
    end else begin
      ext_ff <= nxt_ext;
      req_ff <= nxt_req;
    end
  end

  assign o_save_req     = req_ff[`EXT_BIT_STORE];
  assign o_factory_req  = req_ff[`EXT_BIT_FACTORY];
  assign o_restore_req  = req_ff[`EXT_BIT_RESTORE];
  assign o_ext_error    = req_ff[`EXT_BIT_EXT_ERROR];
  assign o_check_enable = !ext_ff[`EXT_BIT_NO_CHECK];
  assign o_device_lock  = i_motor_stopped
                          && (ext_ff[`EXT_BIT_NO_CHECK] || ext_ff[`EXT_BIT_LOCK]);

  // ----------------------------------------------------------------
  // Status and read port
  // ----------------------------------------------------------------
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  always_comb begin
    o_status = 16'h0000;
    o_status[0] = |req_ff[2:0];
    o_status[`STAT_BIT_CHECK] = o_check_enable && i_check_busy;
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      nxt_rdata = (i_reg_addr == `EXT_CTRL_ADDR) ? ext_ff : 16'h0000;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign o_reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_store_edge_req: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ext_wr && wr_val[1] && !ext_ff[1]) |=> o_save_req)
    else $error("Store edge did not raise save request");
  a_store_self_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (o_save_req && i_nvm_ack && !ext_wr) |=> (!o_save_req && !ext_ff[1]))
    else $error("Store bit not cleared on accept");
  a_restore_powered: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ext_wr && i_motor_powered && !o_restore_req) |=> !o_restore_req)
    else $error("Restore accepted while powered");
  a_ext_err_edge: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ext_wr && wr_val[3] && !ext_ff[3]) |=> o_ext_error)
    else $error("External error edge missed");
  a_lock_nocheck: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (ext_ff[15] && i_motor_stopped) |-> (o_device_lock && !o_check_enable))
    else $error("Check disable did not lock");
  a_status_check: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_status[1] == (!ext_ff[15] && i_check_busy))
    else $error("Check status bit wrong");
  a_map_refuse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    refused |-> (nxt_map[i_map_func] == map_ff[i_map_func]) ##1 o_map_refused)
    else $error("Used position not refused");
  a_fb_run: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ($rose(o_fieldbus_active) && i_fieldbus_word[0]) |-> o_run)
    else $error("Run not started on switch");
  a_ignore_wire: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (i_io_profile && nxt_chan == cmd_channel_pkg::CH_FIELDBUS) |=> o_ignore_wire_scheme)
    else $error("Wire scheme not ignored");

endmodule

//--- sim/plc_master_model.sv
// Fieldbus master model driving the fieldbus command word
module plc_master_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_data,
  input  wire logic        i_switch,
  input  wire logic        i_start,
  output logic      [15:0] o_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] word_ff;
  always @(posedge i_ref_clk) begin
    word_ff <= {i_data[15:6], i_switch, i_data[4:1], i_data[0] & i_start};
  end
  always @(negedge i_ref_clk) begin
    o_word <= word_ff;
  end
endmodule

//--- sim/command_channel_and_ext_control_tb.sv
// Testbench of the command channel block
module command_channel_and_ext_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, wr, rd, map_wr, powered, stopped, ack, busy, src, sw, start;
  logic        rd_pend_ff, refused, fb, ign, run, save, fac, rest, xerr, chk_en, lock, prof;
  logic [3:0]  term, fact, tfree;
  logic [15:0] addr, wdata, data, word, rdata, status;
  logic [1:0]  mfunc;
  logic [4:0]  mbit;
  logic [15:0] rq[$];
  int          miscompares, checked;
  integer      seed;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  command_channel_and_ext_control command_channel_and_ext_control_inst (
    .i_ref_clk(clk), .i_reset(rst), .i_io_profile(prof), .i_three_wire(1'b1),
    .i_switch_from_word(src), .i_switch_index(4'h5), .i_fieldbus_word(word),
    .i_terminal_in(term), .i_map_wr(map_wr), .i_map_func(mfunc), .i_map_bit(mbit),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_motor_powered(powered), .i_motor_stopped(stopped), .i_nvm_ack(ack),
    .i_check_busy(busy), .o_reg_rdata(rdata), .o_map_refused(refused),
    .o_func_active(fact), .o_terminal_free(tfree), .o_fieldbus_active(fb),
    .o_ignore_wire_scheme(ign), .o_run(run), .o_save_req(save), .o_factory_req(fac),
    .o_restore_req(rest), .o_ext_error(xerr), .o_check_enable(chk_en),
    .o_device_lock(lock), .o_status(status));
  plc_master_model plc_master_model_inst (
    .i_ref_clk(clk), .i_data(data), .i_switch(sw), .i_start(start), .o_word(word));
  task report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task compare(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick;
    @(negedge clk);
  endtask
  // Single extended control write, never repeated cyclically
  task wr_ext(input logic [15:0] d);
    wdata = d;
    wr = 1'b1;
    tick;
    wr = 1'b0;
    tick;
  endtask
  task rd_reg(input logic [15:0] a, input logic [15:0] exp);
    addr = a;
    rd = 1'b1;
    rq.push_back(exp);
    tick;
    rd = 1'b0;
    addr = 16'h2138;
    tick;
  endtask
  task pulse_ack;
    ack = 1'b1;
    tick;
    ack = 1'b0;
    tick;
  endtask
  task map(input logic [1:0] f, input logic [4:0] b, input logic exp);
    mfunc = f;
    mbit = b;
    map_wr = 1'b1;
    tick;
    map_wr = 1'b0;
    compare(refused, exp);
    tick;
  endtask
  always @(posedge clk) rd_pend_ff <= rd;
  always @(negedge clk) begin
    if (rd_pend_ff === 1'b1 && rq.size() > 0)
      compare(rdata, rq.pop_front());
  end
  initial begin
    #(2000 * 50);
    miscompares++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; map_wr = 1'b0; powered = 1'b0; stopped = 1'b1;
    ack = 1'b0; busy = 1'b0; src = 1'b0; sw = 1'b0; start = 1'b0; term = 4'h0;
    data = 16'h0000; addr = 16'h2138; wdata = 16'h0000; mfunc = 2'h0; mbit = 5'h00;
    prof = 1'b1;
    miscompares = 0; checked = 0; seed = 32'hc6db_be2f;
    repeat (8) tick;
    rst = 1'b0;
    rd_reg(16'h2138, 16'h0000);
    wr_ext(16'h0002);
    compare({save, status[0]}, 16'h0003);
    pulse_ack;
    compare(save, 16'h0000);
    powered = 1'b1;
    wr_ext(16'h0005);
    compare({fac, rest}, 16'h0000);
    powered = 1'b0;
    wr_ext(16'h0000);
    wr_ext(16'h0005);
    compare({fac, rest}, 16'h0003);
    pulse_ack;
    busy = 1'b1;
    wr_ext(16'h8008);
    compare({xerr, chk_en, lock, status[1]}, 16'h000a);
    stopped = 1'b0;
    tick;
    compare(lock, 16'h0000);
    rd_reg(16'h2138, 16'h8008);
    rd_reg(16'h2139, 16'h0000);
    wr_ext(16'h0000);
    compare({xerr, chk_en, status[1]}, 16'h0003);
    map(2'h0, 5'h02, 1'b0);
    compare(tfree[2], 16'h0000);
    map(2'h1, 5'h02, 1'b1);
    start = 1'b1;
    for (int i = 0; i < 8; i++) begin
      term = 4'($random(seed));
      data = 16'($random(seed));
      tick;
      tick;
      compare({fb, ign}, {14'h0000, term[1], term[1]});
      compare(fact[0], term[1] ? data[2] : term[2]);
      if (term[1])
        compare(run, data[0]);
    end
    term = 4'h0;
    tick;
    tick;
    prof = 1'b0;
    term = 4'h3;
    tick;
    tick;
    compare({fb, ign}, 16'h0002);
    term = 4'h0;
    tick;
    tick;
    prof = 1'b1;
    src = 1'b1;
    term = 4'h0;
    map(2'h2, 5'h05, 1'b1);
    data = 16'h0001;
    sw = 1'b1;
    tick;
    tick;
    compare({fb, run}, 16'h0003);
    sw = 1'b0;
    start = 1'b0;
    tick;
    tick;
    sw = 1'b1;
    tick;
    tick;
    compare({fb, run}, 16'h0002);
    report_and_stop;
  end
endmodule
